// File: hb_ctrl_pkg.sv
// Shared constants, register map and types for the half-bridge control block
package hb_ctrl_pkg;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // Control word fields (bridge_override_reg)
  localparam int CTRL_DIS_POS = 0;
  localparam int CTRL_LVL_POS = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Configuration word fields (config_bank_c / config_bank_d merged)
  localparam int CFG_SLEW_POS = 0;
  localparam int CFG_LIMIT_POS = 3;
  localparam int CFG_OFFT_POS = 6;
  localparam int CFG_SPREAD_POS = 8;
  localparam int CFG_DSEL_POS = 9;
  localparam int CFG_LSEL_POS = 10;
  localparam logic [10:0] CFG_RST = 11'h000;

  // Command word fields
  localparam int CMD_KEY_POS = 0;
  localparam int CMD_CLR_POS = 8;
  localparam logic [7:0] UNLOCK_KEY = 8'hA5;
  localparam logic [7:0] LOCK_KEY = 8'h5A;

  localparam int STAT_CMP_POS = 0;
  localparam int STAT_UNLOCK_POS = 1;
  localparam int STAT_STATE_POS = 2;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int OFF_TIME_HW_US = 30;
  localparam int OFF_TIME_MIN_US = 20;
  localparam int OFF_TIME_STEP_US = 10;
  localparam int BLANK_TIME_NS = 2000;
  localparam int DEAD_TIME_NS = 100;
  localparam int DEAD_CYC = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_CYC = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int OFF_HW_CYC = OFF_TIME_HW_US * CLK_MHZ;
  localparam int SPREAD_PCT = 12;
  localparam int SPREAD_KHZ = 1300;
  localparam int SPREAD_HALF_CYC = (CLK_MHZ * 1000) / (SPREAD_KHZ * 2);
  localparam int SPREAD_STEPS = 2 * SPREAD_PCT;
  localparam logic [2:0] LIMIT_OFF = 3'h0;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_STANDBY = 2'b01,
    ST_ACTIVE = 2'b11
  } dev_state_t;

  typedef enum logic [1:0] {
    GATE_OFF = 2'b00,
    GATE_LOW = 2'b01,
    GATE_DEAD = 2'b11,
    GATE_HIGH = 2'b10
  } gate_state_t;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic out_en;
    logic mirror_en;
  } bridge_drive_t;

endpackage : hb_ctrl_pkg

// File: hb_ctrl.sv
// Half-bridge control logic with register override, slew select and fixed off-time regulation
// Operation
// R1: Sleep if sleep_bar low; standby if disabled; else drive output per level.
// R2: Undriven pins default sleep_bar low, level low, disable high: output Hi-Z.
// R3: Dead time inserted on every high/low side switchover; no external timing.
// R4: Mirror output carries current only while high side fully on.
// R5: Override bits act only after unlock key written to command register.
// R6: Effective input is pin OR override when select 0, AND when 1.
// R7: Only the sleep_bar pin enters sleep; no register path to sleep.
// R8: Slew selector: six pin levels hardwired, eight register settings serial.
// R9: Hardwired slew pin sampled at initialization only, later changes ignored.
// R10: Serial slew setting write accepted any time, effective at once.
// R11: Serial spread clock modulates oscillator +/-12 percent, triangular near 1.3 MHz; code steps every 2 cycles, 96-cycle period, about 1.04 MHz.
// R12: Sense above selected reference forces output low for one off time.
// R13: Off time 30 us hardwired; serial 20 to 50 us by selector.
// R14: Regulation acts only while high side commanded on and sensing valid.
// R15: Any input change during off time ends it; output follows inputs.
// R16: Comparator ignored while output slewing.
// R17: Comparator masked for blank time after leaving low-side recirculation.
// R18: Limit code 0 disables; 1..7 select references; pin omits codes 2, 3.
// R19: Hardwired limit pin transparent, changes take effect immediately.
// R20: Serial limit setting write accepted any time, effective immediately.
// R21: Limit comparator flag set in status, no fault pin, held until clear.
// R22: Inputs accept static levels or PWM, continuous or switched drive.
// R23: Off time and blank time timed by counters from selected durations.
// R24: Comparator and slew-done inputs synchronized before use.
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module hb_ctrl
  import hb_ctrl_pkg::*;
#(
  parameter bit SERIAL_VARIANT = 1'b1,
  parameter int OFF_HW_CYCLES = OFF_HW_CYC,
  parameter int OFF_STEP_CYCLES = OFF_TIME_STEP_US * CLK_MHZ,
  parameter int OFF_MIN_CYCLES = OFF_TIME_MIN_US * CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Control pins, already resolved with their default pulls
  input wire logic sleep_bar_i,
  input wire logic output_disable_i,
  input wire logic level_cmd_i,
  input wire logic [2:0] slew_pin_i,
  input wire logic [2:0] current_limit_level_i,
  // Analog feedback
  input wire logic limit_cmp_i,
  input wire logic slew_done_i,
  // Bridge outputs
  output logic hs_gate_o,
  output logic ls_gate_o,
  output logic out_drive_en_o,
  output logic current_mirror_en_o,
  output logic [2:0] slew_sel_o,
  output logic [2:0] limit_sel_o,
  output logic [4:0] osc_trim_o,
  output logic fault_flag_n_o
);

  localparam int OFF_W = 16;
  localparam int BLK_W = 12;

  // Three-stage pin synchronizers
  logic [2:0] sleep_sync_ff;
  logic [2:0] dis_sync_ff;
  logic [2:0] lvl_sync_ff;
  logic [2:0] cmp_sync_ff;
  logic [2:0] done_sync_ff;
  logic sleep_q_ff;
  logic dis_q_ff;
  logic lvl_q_ff;
  logic cmp_q_ff;
  logic done_q_ff;

  function automatic logic settle(input logic [2:0] s, input logic prev);
    settle = (s[1] == s[2]) ? s[2] : prev;
  endfunction : settle

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_sync_ff <= 3'h0;
      dis_sync_ff <= 3'h7;
      lvl_sync_ff <= 3'h0;
      cmp_sync_ff <= 3'h0;
      done_sync_ff <= 3'h0;
      sleep_q_ff <= 1'b0;
      dis_q_ff <= 1'b1;
      lvl_q_ff <= 1'b0;
      cmp_q_ff <= 1'b0;
      done_q_ff <= 1'b0;
    end else begin
      sleep_sync_ff <= {sleep_sync_ff[1:0], sleep_bar_i};
      dis_sync_ff <= {dis_sync_ff[1:0], output_disable_i};
      lvl_sync_ff <= {lvl_sync_ff[1:0], level_cmd_i};
      cmp_sync_ff <= {cmp_sync_ff[1:0], limit_cmp_i}; // R24
      done_sync_ff <= {done_sync_ff[1:0], slew_done_i}; // R24
      sleep_q_ff <= settle(sleep_sync_ff, sleep_q_ff); // R2
      dis_q_ff <= settle(dis_sync_ff, dis_q_ff); // R2
      lvl_q_ff <= settle(lvl_sync_ff, lvl_q_ff);
      cmp_q_ff <= settle(cmp_sync_ff, cmp_q_ff);
      done_q_ff <= settle(done_sync_ff, done_q_ff);
    end
  end

  // Register file
  logic [1:0] ctrl_ff;
  logic [10:0] cfg_ff;
  logic unlock_ff;
  logic cmp_flag_ff;
  logic init_ff;
  logic [2:0] slew_latch_ff;
  logic wb_hit;
  logic wr_cmd;
  logic clr_req;
  logic cmp_event;
  dev_state_t state_ff;

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cmd = wb_hit && wb_we_i && (wb_adr_i == ADDR_CMD) && SERIAL_VARIANT;
  assign clr_req = wr_cmd && wb_sel_i[1] && wb_dat_i[CMD_CLR_POS];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
      cfg_ff <= CFG_RST;
    end else if (wb_hit && wb_we_i && SERIAL_VARIANT) begin
      if (wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
        ctrl_ff <= wb_dat_i[1:0];
      end
      if (wb_adr_i == ADDR_CFG) begin
        if (wb_sel_i[0]) begin
          cfg_ff[7:0] <= wb_dat_i[7:0]; // R10 R20
        end
        if (wb_sel_i[1]) begin
          cfg_ff[10:8] <= wb_dat_i[10:8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_ff <= 1'b0;
    end else if (wr_cmd && wb_sel_i[0]) begin
      if (wb_dat_i[7:0] == UNLOCK_KEY) begin
        unlock_ff <= 1'b1; // R5
      end else if (wb_dat_i[7:0] == LOCK_KEY) begin
        unlock_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_CTRL: wb_dat_o <= {30'h0, ctrl_ff};
        ADDR_CFG: wb_dat_o <= {21'h0, cfg_ff};
        ADDR_STATUS: wb_dat_o <= {28'h0, state_ff, unlock_ff, cmp_flag_ff};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Effective inputs; sleep has no register path
  logic eff_dis;
  logic eff_lvl;
  logic ovr_dis;
  logic ovr_lvl;

  function automatic logic combine(input logic pin, input logic bit_v, input logic sel);
    combine = sel ? (pin & bit_v) : (pin | bit_v);
  endfunction : combine

  always_comb begin
    ovr_dis = 1'b0;
    ovr_lvl = 1'b0;
    eff_dis = dis_q_ff;
    eff_lvl = lvl_q_ff;
    if (SERIAL_VARIANT && unlock_ff) begin // R5
      ovr_dis = ctrl_ff[CTRL_DIS_POS];
      ovr_lvl = ctrl_ff[CTRL_LVL_POS];
      eff_dis = combine(dis_q_ff, ovr_dis, cfg_ff[CFG_DSEL_POS]); // R6
      eff_lvl = combine(lvl_q_ff, ovr_lvl, cfg_ff[CFG_LSEL_POS]); // R6
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_SLEEP;
    end else if (!sleep_q_ff) begin
      state_ff <= ST_SLEEP; // R1 R7
    end else if (eff_dis) begin
      state_ff <= ST_STANDBY; // R1
    end else begin
      state_ff <= ST_ACTIVE; // R1 R22
    end
  end

  // Initialization latch of the hardwired slew pin on reset or wake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_ff <= 1'b1;
      slew_latch_ff <= 3'h0;
    end else if (state_ff == ST_SLEEP) begin
      init_ff <= 1'b1;
    end else if (init_ff) begin
      init_ff <= 1'b0;
      slew_latch_ff <= (slew_pin_i > 3'h5) ? 3'h5 : slew_pin_i; // R8 R9
    end
  end

  // Regulation: off-time, blanking and dead-time counters
  logic [2:0] limit_eff;
  logic [OFF_W-1:0] off_cnt_ff;
  logic [BLK_W-1:0] blank_cnt_ff;
  logic [7:0] dead_cnt_ff;
  logic off_act_ff;
  logic [1:0] cmd_prev_ff;
  logic cmd_change;
  logic hs_cmd;
  logic sense_ok;
  gate_state_t gate_ff;
  logic want_high;

  function automatic logic [2:0] pin_limit(input logic [2:0] p);
    pin_limit = (p == 3'h2 || p == 3'h3) ? 3'h4 : p; // R18
  endfunction : pin_limit

  function automatic logic [OFF_W-1:0] off_len(input logic [1:0] sel);
    if (SERIAL_VARIANT) begin
      off_len = OFF_W'(OFF_MIN_CYCLES + int'(sel) * OFF_STEP_CYCLES);
    end else begin
      off_len = OFF_W'(OFF_HW_CYCLES);
    end
  endfunction : off_len

  assign limit_eff = SERIAL_VARIANT ? cfg_ff[CFG_LIMIT_POS +: 3] : pin_limit(current_limit_level_i); // R19 R20
  assign cmd_change = {eff_dis, eff_lvl} != cmd_prev_ff;
  assign hs_cmd = (state_ff == ST_ACTIVE) && eff_lvl;
  assign sense_ok = (gate_ff == GATE_HIGH) && done_q_ff && (blank_cnt_ff == '0); // R16 R17
  assign cmp_event = hs_cmd && sense_ok && (limit_eff != LIMIT_OFF) && cmp_q_ff; // R14 R18
  assign want_high = hs_cmd && !off_act_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_prev_ff <= 2'b10;
      off_act_ff <= 1'b0;
      off_cnt_ff <= '0;
    end else begin
      cmd_prev_ff <= {eff_dis, eff_lvl};
      if (cmd_change || !hs_cmd) begin
        off_act_ff <= 1'b0; // R15
        off_cnt_ff <= '0;
      end else if (off_act_ff) begin
        off_cnt_ff <= off_cnt_ff - OFF_W'(1); // R23
        if (off_cnt_ff == OFF_W'(1)) begin
          off_act_ff <= 1'b0;
        end
      end else if (cmp_event) begin
        off_act_ff <= 1'b1; // R12 R13
        off_cnt_ff <= off_len(cfg_ff[CFG_OFFT_POS +: 2]);
      end
    end
  end

  // Gate sequencing with dead time on each side change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_ff <= GATE_OFF;
      dead_cnt_ff <= '0;
      blank_cnt_ff <= '0;
    end else begin
      if (gate_ff == GATE_HIGH && blank_cnt_ff != '0) begin
        blank_cnt_ff <= blank_cnt_ff - BLK_W'(1); // R17 R23
      end
      unique case (gate_ff)
        GATE_OFF: begin
          if (state_ff == ST_ACTIVE) begin
            gate_ff <= GATE_DEAD;
            dead_cnt_ff <= 8'(DEAD_CYC);
          end
        end
        GATE_LOW: begin
          if (state_ff != ST_ACTIVE) begin
            gate_ff <= GATE_OFF;
          end else if (want_high) begin
            gate_ff <= GATE_DEAD; // R3
            dead_cnt_ff <= 8'(DEAD_CYC);
            blank_cnt_ff <= BLK_W'(BLANK_CYC);
          end
        end
        GATE_HIGH: begin
          if (state_ff != ST_ACTIVE) begin
            gate_ff <= GATE_OFF;
          end else if (!want_high) begin
            gate_ff <= GATE_DEAD; // R3
            dead_cnt_ff <= 8'(DEAD_CYC);
          end
        end
        GATE_DEAD: begin
          if (state_ff != ST_ACTIVE) begin
            gate_ff <= GATE_OFF;
          end else if (dead_cnt_ff > 8'h01) begin
            dead_cnt_ff <= dead_cnt_ff - 8'h01;
          end else begin
            gate_ff <= want_high ? GATE_HIGH : GATE_LOW;
          end
        end
      endcase
    end
  end

  // Sticky comparator flag; set wins over clear, sleep clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_flag_ff <= 1'b0;
    end else if (cmp_event && SERIAL_VARIANT) begin
      cmp_flag_ff <= 1'b1; // R21
    end else if (clr_req || state_ff == ST_SLEEP) begin
      cmp_flag_ff <= 1'b0; // R21
    end
  end

  // Spread spectrum trim: triangle over +/- SPREAD_PCT steps
  logic [7:0] spread_div_ff;
  logic [4:0] tri_ff;
  logic tri_up_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i || !SERIAL_VARIANT || !cfg_ff[CFG_SPREAD_POS]) begin
      spread_div_ff <= '0;
      tri_ff <= 5'(SPREAD_PCT);
      tri_up_ff <= 1'b1;
    end else if (spread_div_ff >= 8'(SPREAD_HALF_CYC / SPREAD_STEPS)) begin
      spread_div_ff <= '0; // R11
      if (tri_up_ff) begin
        tri_ff <= tri_ff + 5'h01;
        tri_up_ff <= tri_ff < 5'(SPREAD_STEPS - 1);
      end else begin
        tri_ff <= tri_ff - 5'h01;
        tri_up_ff <= tri_ff <= 5'h01;
      end
    end else begin
      spread_div_ff <= spread_div_ff + 8'h01;
    end
  end

  // Registered outputs
  bridge_drive_t drv;

  always_comb begin
    drv.hs_on = (gate_ff == GATE_HIGH) && (state_ff == ST_ACTIVE); // R1
    drv.ls_on = (gate_ff == GATE_LOW) && (state_ff == ST_ACTIVE); // R1
    drv.out_en = state_ff == ST_ACTIVE;
    drv.mirror_en = drv.hs_on && done_q_ff; // R4
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_gate_o <= 1'b0;
      ls_gate_o <= 1'b0;
      out_drive_en_o <= 1'b0;
      current_mirror_en_o <= 1'b0;
      slew_sel_o <= 3'h0;
      limit_sel_o <= 3'h0;
      osc_trim_o <= 5'(SPREAD_PCT);
      fault_flag_n_o <= 1'b1;
    end else begin
      hs_gate_o <= drv.hs_on;
      ls_gate_o <= drv.ls_on;
      out_drive_en_o <= drv.out_en;
      current_mirror_en_o <= drv.mirror_en; // R4
      slew_sel_o <= SERIAL_VARIANT ? cfg_ff[CFG_SLEW_POS +: 3] : slew_latch_ff; // R8 R10
      limit_sel_o <= limit_eff;
      osc_trim_o <= tri_ff;
      fault_flag_n_o <= 1'b1; // R21
    end
  end

endmodule : hb_ctrl
`default_nettype wire

// File: hb_ctrl_monitor.sv
// Port-level checker for the half-bridge control block
`timescale 1ns/1ps
`default_nettype none

module hb_ctrl_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sleep_bar_i,
  input wire logic hs_gate_o,
  input wire logic ls_gate_o,
  input wire logic out_drive_en_o,
  input wire logic current_mirror_en_o,
  input wire logic [4:0] osc_trim_o,
  input wire logic fault_flag_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_no_shoot: assert property (!(hs_gate_o && ls_gate_o)) else $error("both gates on");
  a_dead_after_low: assert property ($fell(ls_gate_o) |-> !hs_gate_o [*8]) else $error("no gap low to high");
  a_dead_after_high: assert property ($fell(hs_gate_o) |-> !ls_gate_o [*8]) else $error("no gap high to low");
  a_sleep_off: assert property (!sleep_bar_i [*8] |-> !out_drive_en_o && !hs_gate_o && !ls_gate_o)
    else $error("drive while asleep");
  a_gate_needs_drive: assert property (hs_gate_o || ls_gate_o |-> out_drive_en_o) else $error("gate without drive");
  a_mirror_high_only: assert property (current_mirror_en_o |-> hs_gate_o || $past(hs_gate_o))
    else $error("mirror without high side");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_no_fault_pin: assert property (fault_flag_n_o) else $error("fault pin asserted");
  a_trim_range: assert property (osc_trim_o <= 5'h18) else $error("trim out of span");

  c_regulation_cut: cover property ($fell(hs_gate_o) && out_drive_en_o);
  c_mirror_on: cover property ($rose(current_mirror_en_o));
  c_bus_access: cover property (wb_ack_o);
endmodule : hb_ctrl_monitor

bind hb_ctrl hb_ctrl_monitor u_hb_ctrl_monitor (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .sleep_bar_i(sleep_bar_i),
  .hs_gate_o(hs_gate_o),
  .ls_gate_o(ls_gate_o),
  .out_drive_en_o(out_drive_en_o),
  .current_mirror_en_o(current_mirror_en_o),
  .osc_trim_o(osc_trim_o),
  .fault_flag_n_o(fault_flag_n_o)
);

`default_nettype wire

// File: load_model.sv
// Behavioural load and sense comparator seen by the bridge
`timescale 1ns/1ps
`default_nettype none

module load_model (
  input wire logic clk_i,
  input wire logic hs_gate_i,
  input wire logic ls_gate_i,
  input wire logic cmp_req_i,
  output logic slew_done_o,
  output logic limit_cmp_o
);
  logic [2:0] settle_ff = 3'h0;
  logic hs_q_ff = 1'b0;
  logic ls_q_ff = 1'b0;

  always_ff @(posedge clk_i) begin
    hs_q_ff <= hs_gate_i;
    ls_q_ff <= ls_gate_i;
    if (hs_gate_i != hs_q_ff || ls_gate_i != ls_q_ff) begin
      settle_ff <= 3'h0;
    end else if (settle_ff != 3'h7) begin
      settle_ff <= settle_ff + 3'h1;
    end
  end

  // Output swing takes several cycles after any gate change
  assign slew_done_o = (settle_ff == 3'h7) && (hs_gate_i || ls_gate_i);
  // Spikes pass during slewing too, as a real load would give them
  assign limit_cmp_o = cmp_req_i && hs_gate_i;
endmodule : load_model

`default_nettype wire

// File: tb.sv
// Self-checking testbench for the half-bridge control block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import hb_ctrl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rdata;
  logic wb_ack;
  logic sleep_bar = 1'b0;
  logic dis = 1'b1;
  logic lvl = 1'b0;
  logic cmp_req = 1'b0;
  logic slew_done, limit_cmp, hs, ls, drv, mir, fault_n;
  logic [2:0] slew_sel, limit_sel;
  logic [4:0] trim;
  logic [31:0] rd;
  int n_fail = 0;
  int comparisons = 0;
  int n;

  always #5 clk_i = ~clk_i;

  hb_ctrl #(.OFF_STEP_CYCLES(10), .OFF_MIN_CYCLES(20)) u_hb_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdata), .wb_ack_o(wb_ack),
    .sleep_bar_i(sleep_bar), .output_disable_i(dis), .level_cmd_i(lvl), .slew_pin_i(3'h2),
    .current_limit_level_i(3'h4), .limit_cmp_i(limit_cmp), .slew_done_i(slew_done),
    .hs_gate_o(hs), .ls_gate_o(ls), .out_drive_en_o(drv), .current_mirror_en_o(mir),
    .slew_sel_o(slew_sel), .limit_sel_o(limit_sel), .osc_trim_o(trim), .fault_flag_n_o(fault_n));

  load_model u_load_model (.clk_i(clk_i), .hs_gate_i(hs), .ls_gate_i(ls), .cmp_req_i(cmp_req),
    .slew_done_o(slew_done), .limit_cmp_o(limit_cmp));

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One classic cycle; held until the ack edge, read data taken there
  task wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_xfer

  // Pins pass a synchroniser and dead time before the bridge settles
  task pins(input logic s, input logic d, input logic l);
    @(posedge clk_i);
    sleep_bar <= s;
    dis <= d;
    lvl <= l;
    repeat (20) @(posedge clk_i);
  endtask : pins

  task wait_hs(input logic v);
    n = 0;
    while (hs !== v && n < 100) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_hs

  task wrap_up;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    check("status reset", rd, 32'h0);
    check("trim centre", {27'h0, trim}, 32'hC);
    wb_xfer(1'b0, 8'h10, 32'h0);
    check("unmapped", rd, 32'h0);
    wb_xfer(1'b1, ADDR_CFG, 32'hA5);
    repeat (2) @(posedge clk_i);
    check("slew sel", {29'h0, slew_sel}, 32'h5);
    check("limit sel", {29'h0, limit_sel}, 32'h4);
    pins(1'b1, 1'b1, 1'b0);
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    check("standby", rd, 32'h4);
    check("standby drv", {31'h0, drv}, 32'h0);
    pins(1'b1, 1'b0, 1'b0);
    check("low gate", {30'h0, hs, ls}, 32'h1);
    pins(1'b1, 1'b0, 1'b1);
    check("high gate", {29'h0, hs, ls, drv}, 32'h5);
    // Mirror waits for the load to settle and its synchroniser
    repeat (12) @(posedge clk_i);
    check("mirror", {31'h0, mir}, 32'h1);
    wb_xfer(1'b1, ADDR_CTRL, 32'h1);
    repeat (20) @(posedge clk_i);
    check("locked override", {31'h0, drv}, 32'h1);
    wb_xfer(1'b1, ADDR_CMD, 32'hA5);
    repeat (20) @(posedge clk_i);
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    check("or override", rd, 32'h6);
    wb_xfer(1'b1, ADDR_CFG, 32'h2A5);
    wb_xfer(1'b1, ADDR_CTRL, 32'h3);
    repeat (20) @(posedge clk_i);
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    check("and override", rd & 32'hC, 32'hC);
    check("and drive", {30'h0, hs, drv}, 32'h3);
    repeat (210) @(posedge clk_i);
    cmp_req <= 1'b1;
    wait_hs(1'b0);
    check("cut", {31'h0, hs}, 32'h0);
    cmp_req <= 1'b0;
    n = 0;
    while (ls !== 1'b1 && n < 30) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (ls === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    // Low phase is the off time less the dead time ahead of it
    check("off time", {31'h0, (n >= 39 - DEAD_CYC && n <= 42 - DEAD_CYC)}, 32'h1);
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    check("cmp flag", rd & 32'h1, 32'h1);
    wait_hs(1'b1);
    // Spike right after recirculation must be masked
    cmp_req <= 1'b1;
    repeat (100) @(posedge clk_i);
    check("blank", {31'h0, hs}, 32'h1);
    cmp_req <= 1'b0;
    wb_xfer(1'b1, ADDR_CFG, 32'h6E5);
    repeat (210) @(posedge clk_i);
    cmp_req <= 1'b1;
    wait_hs(1'b0);
    cmp_req <= 1'b0;
    repeat (5) @(posedge clk_i);
    lvl <= 1'b0;
    repeat (15) @(posedge clk_i);
    lvl <= 1'b1;
    wait_hs(1'b1);
    check("abort", {31'h0, (n < 30)}, 32'h1);
    wb_xfer(1'b1, ADDR_CFG, 32'h2C5);
    repeat (210) @(posedge clk_i);
    cmp_req <= 1'b1;
    repeat (50) @(posedge clk_i);
    check("limit off", {31'h0, hs}, 32'h1);
    cmp_req <= 1'b0;
    wb_xfer(1'b1, ADDR_CMD, 32'h100);
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    check("flag clear", rd & 32'h1, 32'h0);
    wb_xfer(1'b1, ADDR_CFG, 32'h3C5);
    repeat (10) @(posedge clk_i);
    check("trim moves", {31'h0, (trim != 5'hC && trim <= 5'h18)}, 32'h1);
    pins(1'b0, 1'b0, 1'b1);
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    check("sleep", rd & 32'hD, 32'h0);
    check("sleep out", {29'h0, hs, ls, drv}, 32'h0);
    wrap_up();
  end
endmodule : tb

`default_nettype wire
